// ### src/iirp_consts.vh
// Purpose: Constants for the isolated input read port.
// Assumes: 8-bit host I/O bus, ten address lines.
// Notes: Offsets are within the four-address window.
`ifndef IIRP_CONSTS_VH
`define IIRP_CONSTS_VH
`define IIRP_ADDR_W 10
`define IIRP_WIN_SIZE 4
`define IIRP_OFS_LOW 2'h0
`define IIRP_OFS_HIGH 2'h1
`define IIRP_FILL_BYTE 8'hFF
`define IIRP_BASE_DEFAULT 8'hC0
`define IIRP_IRQ_LINES 6
`define IIRP_IRQ_SEL_DEFAULT 3'h0
`define IIRP_OFS_W 2
`define IIRP_LOW_LSB 0
`define IIRP_LOW_MSB 7
`define IIRP_HIGH_LSB 8
`define IIRP_HIGH_MSB 15
`define IIRP_IRQ_CHANNEL 0
`define IIRP_RDATA_RESET 8'h00
`endif

// ### src/iirp_sync.v
// Purpose: Two-stage synchroniser for a bundle of levels.
// Assumes: Inputs are asynchronous to clk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module iirp_sync #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Data
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// ### src/iirp_top.v
// Purpose: Sixteen-channel isolated input read port on an 8-bit host I/O bus.
// Assumes: Bus strobes are synchronised and one cycle long; strap inputs static.
// Notes: Read data registered one cycle after the read strobe.
`timescale 1ns/1ps
`include "iirp_consts.vh"
module iirp_top #(
  parameter CHANNELS = 16
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Isolated inputs, high when energised
  input wire [7:0] input_channels_lower,
  input wire [7:0] input_channels_upper,
  // Static configuration
  input wire [7:0] base_address_switch,
  input wire [2:0] interrupt_line_select,
  // Host I/O bus
  input wire [`IIRP_ADDR_W-1:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  output reg [7:0] bus_rdata,
  output reg bus_rvalid,
  output reg bus_sel,
  // Host interrupt lines 2 to 7
  output reg [`IIRP_IRQ_LINES-1:0] irq_lines
);
  // ----------------------------------------
  // Local sizes
  // ----------------------------------------
  // Offset bits below the base, base bits above
  localparam BYTE_W = 8;
  localparam OFS_W = `IIRP_OFS_W;
  localparam SEL_W = 3;
  localparam BASE_W = `IIRP_ADDR_W - `IIRP_OFS_W;
  localparam LINES = `IIRP_IRQ_LINES;
  localparam CH_IRQ = `IIRP_IRQ_CHANNEL;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Synchronised channel levels
  wire [CHANNELS-1:0] chan_sync;

  // Strap staging, two flops per strap
  reg [BASE_W-1:0] base_meta_reg;
  reg [BASE_W-1:0] base_reg;
  reg [SEL_W-1:0] irq_sel_meta_reg;
  reg [SEL_W-1:0] irq_sel_reg;

  // Access decode
  reg hit;
  reg rd_take;
  reg wr_take;
  reg [OFS_W-1:0] ofs;
  reg [BYTE_W-1:0] rd_next;

  // Next values of the registered outputs
  reg [BYTE_W-1:0] bus_rdata_next;
  reg bus_rvalid_next;
  reg bus_sel_next;
  reg [LINES-1:0] irq_lines_next;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Upper address bits against the staged base
  function win_match;
    input [`IIRP_ADDR_W-1:0] addr;
    input [BASE_W-1:0] base;
    begin
      win_match = (addr[`IIRP_ADDR_W-1:OFS_W] == base);
    end
  endfunction

  // Byte for one window offset; unused offsets read the fill byte
  function [BYTE_W-1:0] byte_pick;
    input [OFS_W-1:0] sel_ofs;
    input [CHANNELS-1:0] chans;
    begin
      if (sel_ofs == `IIRP_OFS_LOW) begin
        byte_pick = chans[`IIRP_LOW_MSB:`IIRP_LOW_LSB];
      end else if (sel_ofs == `IIRP_OFS_HIGH) begin
        byte_pick = chans[`IIRP_HIGH_MSB:`IIRP_HIGH_LSB];
      end else begin
        byte_pick = `IIRP_FILL_BYTE;
      end
    end
  endfunction

  // One-hot routing of a level; codes past the last line drive none
  function [LINES-1:0] line_route;
    input [SEL_W-1:0] code;
    input level;
    integer k;
    begin
      line_route = {LINES{1'h0}};
      for (k = 0; k < LINES; k = k + 1) begin
        if (code == k[SEL_W-1:0]) begin
          line_route[k] = level;
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  iirp_sync #(
    .WIDTH(CHANNELS)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din({input_channels_upper, input_channels_lower}),
    .dout(chan_sync)
  );

  // ----------------------------------------
  // Strap staging
  // ----------------------------------------
  // Straps are pins too, so two flops before decode reads them
  always @(posedge clk) begin
    if (srst) begin
      base_meta_reg <= `IIRP_BASE_DEFAULT;
      irq_sel_meta_reg <= `IIRP_IRQ_SEL_DEFAULT;
    end else begin
      base_meta_reg <= base_address_switch;
      irq_sel_meta_reg <= interrupt_line_select;
    end
  end

  // Only the second stage is read downstream
  always @(posedge clk) begin
    if (srst) begin
      base_reg <= `IIRP_BASE_DEFAULT;
      irq_sel_reg <= `IIRP_IRQ_SEL_DEFAULT;
    end else begin
      base_reg <= base_meta_reg;
      irq_sel_reg <= irq_sel_meta_reg;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always @* begin
    hit = win_match(bus_addr, base_reg);
    ofs = bus_addr[OFS_W-1:0];
    // A read with a write strobe counts as a write
    rd_take = hit && bus_rd && !bus_wr;
    wr_take = hit && bus_wr;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rd_next = byte_pick(ofs, chan_sync);
  end

  // ----------------------------------------
  // Answer next values
  // ----------------------------------------
  always @* begin
    bus_sel_next = rd_take || wr_take;
    bus_rvalid_next = rd_take;
    // Writes never reach the data register
    if (rd_take) begin
      bus_rdata_next = rd_next;
    end else begin
      bus_rdata_next = bus_rdata;
    end
  end

  // ----------------------------------------
  // Answer registers
  // ----------------------------------------
  // Strobes stand for one cycle
  always @(posedge clk) begin
    if (srst) begin
      bus_rvalid <= 1'h0;
      bus_sel <= 1'h0;
    end else begin
      bus_rvalid <= bus_rvalid_next;
      bus_sel <= bus_sel_next;
    end
  end

  // Read data holds until the next taken read
  always @(posedge clk) begin
    if (srst) begin
      bus_rdata <= `IIRP_RDATA_RESET;
    end else begin
      bus_rdata <= bus_rdata_next;
    end
  end

  // ----------------------------------------
  // Channel 0 interrupt routing
  // ----------------------------------------
  // Only the channel 0 level is ever routed
  always @* begin
    irq_lines_next = line_route(irq_sel_reg, chan_sync[CH_IRQ]);
  end

  // Codes 6 and 7 leave every line low
  always @(posedge clk) begin
    if (srst) begin
      irq_lines <= {LINES{1'h0}};
    end else begin
      irq_lines <= irq_lines_next;
    end
  end
endmodule

// ### test/iirp_properties.sv
// Purpose: bus and irq checks. Assumes: static straps. Notes: bound below.
`timescale 1ns/1ps
module iirp_properties(
  input wire clk,
  input wire srst,
  input wire [7:0] base_address_switch,
  input wire [2:0] interrupt_line_select,
  input wire [9:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_rdata,
  input wire bus_rvalid,
  input wire bus_sel,
  input wire [5:0] irq_lines
);
  wire hit = bus_addr[9:2] == base_address_switch;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence rd_hit; bus_rd && !bus_wr && hit; endsequence
  chk_read_answer: assert property (rd_hit |=> bus_rvalid && bus_sel)
    else $error("no answer");
  chk_fill_byte: assert property (rd_hit ##0 bus_addr[1] |=> bus_rdata == 8'hFF)
    else $error("bad fill");
  chk_no_answer: assert property (!(bus_rd && !bus_wr && hit) |=> !bus_rvalid)
    else $error("stray answer");
  chk_off_window: assert property (!hit |=> !bus_sel)
    else $error("stray select");
  chk_write_sel: assert property (bus_wr && hit |=> bus_sel)
    else $error("no select");
  chk_data_hold: assert property (!bus_rvalid |-> $stable(bus_rdata))
    else $error("data moved");
  chk_one_line: assert property ($onehot0(irq_lines))
    else $error("many lines");
  chk_no_line: assert property ((interrupt_line_select > 5)[*4] |-> irq_lines == 0)
    else $error("line driven");
endmodule
bind iirp_top iirp_properties u_iirp_properties(.*);

// ### test/iirp_host.sv
// Purpose: host bus model. Assumes: one clock. Notes: idle address inverted.
`timescale 1ns/1ps
module iirp_host(
  input wire clk,
  output reg [9:0] bus_addr = 0,
  output reg bus_rd = 0,
  output reg bus_wr = 0
);
  task xfer(input [9:0] a, input r, input w);
    begin
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= r;
      bus_wr <= w;
      @(posedge clk);
      bus_rd <= 0;
      bus_wr <= 0;
      bus_addr <= ~a;
    end
  endtask
endmodule

// ### test/iirp_top_test.sv
// Purpose: random reads and irq routing. Assumes: 50 MHz. Notes: none.
`timescale 1ns/1ps
module iirp_top_test;
  reg clk = 0, srst = 1;
  reg [7:0] lo = 0, hi = 0, base = 8'hC0;
  reg [2:0] sel = 0;
  wire [9:0] a;
  wire rd, wr, rv, bs;
  wire [7:0] rdat;
  wire [5:0] irq;
  integer seed = 32'h0000_2588, miscompares = 0, check_count = 0, i, o, h;
  always #10 clk = ~clk;
  iirp_host u_iirp_host(.clk(clk), .bus_addr(a), .bus_rd(rd), .bus_wr(wr));
  iirp_top u_iirp_top(.clk(clk), .srst(srst), .input_channels_lower(lo),
    .input_channels_upper(hi), .base_address_switch(base), .interrupt_line_select(sel),
    .bus_addr(a), .bus_rd(rd), .bus_wr(wr), .bus_rdata(rdat), .bus_rvalid(rv),
    .bus_sel(bs), .irq_lines(irq));
  task cmp_irq(input [5:0] g, input [5:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t %h %h", $time, g, e);
      end
    end
  endtask
  task cmp_ans(input [1:0] g, input [1:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t %h %h", $time, g, e);
      end
    end
  endtask
  task cmp_data(input [7:0] g, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t %h %h", $time, g, e);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (check_count > 0 && miscompares == 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  function [7:0] exp_rd(input [1:0] f);
    exp_rd = f[1] ? 8'hFF : (f[0] ? hi : lo);
  endfunction
  function [5:0] exp_irq(input [2:0] s, input c0);
    exp_irq = (s < 6) ? ({5'h00, c0} << s) : 6'h00;
  endfunction
  function [1:0] exp_ans(input in_win, input r, input w);
    exp_ans = {in_win && r && !w, in_win && (r || w)};
  endfunction
  initial begin
    #40000;
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge clk);
      lo <= $random(seed);
      hi <= $random(seed);
      sel <= i[2:0];
      o = {$random(seed)} % 127;
      base <= 8'h80 + o[7:0];
      repeat (4) @(posedge clk);
      #1 cmp_irq(irq, exp_irq(sel, lo[0]));
      o = $random(seed);
      h = !i[3];
      u_iirp_host.xfer({base ^ {7'h0, i[3]}, o[1:0]}, o[3], o[2]);
      #1 cmp_ans({rv, bs}, exp_ans(h, o[3], o[2]));
      if (h && o[3] && !o[2]) cmp_data(rdat, exp_rd(o[1:0]));
    end
    results;
  end
endmodule
